// *** rtl/psr_pkg.sv ***
/*
  constants for the supervisor: timing figures and derived cycle counts.
  assumes a 40 MHz system clock feeding every counter.
*/
package psr_pkg;
  // clock rate in hz
  localparam longint CLOCK_HZ          = 40000000;
  // reset stretch, microseconds (130 ms)
  localparam longint RESET_STRETCH_US  = 130000;
  // interrupt pulse width, microseconds
  localparam longint INT_PULSE_US      = 200;
  // sense filter time, microseconds
  localparam longint SENSE_FILTER_US   = 5;
  // watchdog minimum timeout, microseconds (1 second)
  localparam longint WATCHDOG_US       = 1000000;
  // pushbutton debounce time, microseconds
  localparam longint DEBOUNCE_US       = 1;
  // least times round up to whole cycles
  localparam longint RESET_STRETCH_CYC = (RESET_STRETCH_US * CLOCK_HZ + 999999) / 1000000;
  localparam longint INT_PULSE_CYC     = (INT_PULSE_US * CLOCK_HZ + 999999) / 1000000;
  localparam longint SENSE_FILTER_CYC  = (SENSE_FILTER_US * CLOCK_HZ + 999999) / 1000000;
  localparam longint WATCHDOG_CYC      = (WATCHDOG_US * CLOCK_HZ + 999999) / 1000000;
  localparam longint DEBOUNCE_CYC      = (DEBOUNCE_US * CLOCK_HZ + 999999) / 1000000;
  // counter width, wide enough for the one second count
  localparam int     CNT_W             = 26;
  // state of the reset sequencer
  typedef enum logic [1:0] {PSR_HOLD, PSR_STRETCH, PSR_RUN} psr_rst_state_type;
endpackage : psr_pkg

// *** rtl/psr_supervisor.sv ***
/*
  processor supervisor: reset stretcher, pushbutton debounce, filtered
  early-warning interrupt and a strobed watchdog.
  assumes the comparators are outside and give digital levels; all timing
  comes from the 40 MHz clock.
*/
`timescale 1ns/1ps
module psr_supervisor #(
  parameter longint RESET_CYC    = psr_pkg::RESET_STRETCH_CYC,
  parameter longint WATCHDOG_CYC = psr_pkg::WATCHDOG_CYC
) (
  input  wire logic CLOCK_IN,
  input  wire logic RSTN_IN,
  input  wire logic SUPPLY_OK_IN,
  input  wire logic SENSE_LOW_IN,
  input  wire logic MANUAL_RESET_N_IN,
  input  wire logic WATCHDOG_KICK_N_IN,
  output logic      RESET_N_OUT,
  output logic      RESET_OUT,
  output logic      INTERRUPT_N_OUT,
  output logic      WATCHDOG_TIMEOUT_N_OUT
);
  localparam int W = psr_pkg::CNT_W;

  psr_sync_if sync_bus ();

  // true when a counter has reached its terminal count
  function automatic logic reached(input logic [W-1:0] cnt, input longint limit);
    reached = ({{(64-W){1'b0}}, cnt} >= (limit - 1));
  endfunction : reached

  psr_sync u_sync (
    .clock_in           (CLOCK_IN),
    .rstn_in            (RSTN_IN),
    .supply_ok_in       (SUPPLY_OK_IN),
    .sense_low_in       (SENSE_LOW_IN),
    .manual_reset_n_in  (MANUAL_RESET_N_IN),
    .watchdog_kick_n_in (WATCHDOG_KICK_N_IN),
    .sync_bus           (sync_bus.producer)
  );

  // pushbutton debounce state
  logic         button_down;       // debounced pushbutton pressed
  logic [W-1:0] db_cnt;            // stable-level counter
  logic         next_button_down;
  logic [W-1:0] next_db_cnt;

  // debounce: the level must differ from the accepted one long enough
  always_comb begin
    next_button_down = button_down;
    next_db_cnt      = '0;
    if ((~sync_bus.manual_reset_n) != button_down) begin
      next_db_cnt = db_cnt + W'(1);
      if (reached(db_cnt, psr_pkg::DEBOUNCE_CYC)) begin
        next_button_down = ~sync_bus.manual_reset_n;
        next_db_cnt      = '0;
      end
    end
    if (!RSTN_IN) begin
      next_button_down = 1'b0;
      next_db_cnt      = '0;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    button_down <= next_button_down;
    db_cnt      <= next_db_cnt;
  end

  // reset sequencer state
  psr_pkg::psr_rst_state_type rst_state;
  psr_pkg::psr_rst_state_type next_rst_state;
  logic [W-1:0] rst_cnt;          // stretch counter
  logic [W-1:0] next_rst_cnt;
  logic         next_reset_n;

  // hold while supply bad or button down, then stretch, then run
  always_comb begin
    next_rst_state = rst_state;
    next_rst_cnt   = '0;
    case (rst_state)
      psr_pkg::PSR_HOLD: begin
        if (sync_bus.supply_ok && !button_down) begin
          next_rst_state = psr_pkg::PSR_STRETCH;
        end
      end
      psr_pkg::PSR_STRETCH: begin
        next_rst_cnt = rst_cnt + W'(1);
        if (reached(rst_cnt, RESET_CYC)) begin
          next_rst_state = psr_pkg::PSR_RUN;
          next_rst_cnt   = '0;
        end
      end
      psr_pkg::PSR_RUN: begin
        next_rst_state = psr_pkg::PSR_RUN;
      end
      default: begin
        next_rst_state = psr_pkg::PSR_HOLD;
      end
    endcase
    if (!sync_bus.supply_ok || button_down) begin
      next_rst_state = psr_pkg::PSR_HOLD;
      next_rst_cnt   = '0;
    end
    if (!RSTN_IN) begin
      next_rst_state = psr_pkg::PSR_HOLD;
      next_rst_cnt   = '0;
    end
    // reset outputs stay active until the run state
    next_reset_n = (next_rst_state == psr_pkg::PSR_RUN);
  end

  always_ff @(posedge CLOCK_IN) begin
    rst_state   <= next_rst_state;
    rst_cnt     <= next_rst_cnt;
    RESET_N_OUT <= next_reset_n;
    RESET_OUT   <= ~next_reset_n;
  end

  // early-warning interrupt state
  logic [W-1:0] filt_cnt;          // below-trip dwell counter
  logic [W-1:0] pulse_cnt;         // interrupt pulse counter
  logic         pulse_on;          // interrupt active
  logic         armed;             // allowed to fire again after sense recovers
  logic [W-1:0] next_filt_cnt;
  logic [W-1:0] next_pulse_cnt;
  logic         next_pulse_on;
  logic         next_armed;

  // one pulse per excursion; re-armed when sense goes back above trip
  always_comb begin
    next_filt_cnt  = '0;
    next_pulse_cnt = '0;
    next_pulse_on  = pulse_on;
    next_armed     = armed;
    if (!sync_bus.sense_low) begin
      next_armed = 1'b1;
    end
    if (sync_bus.sense_low && sync_bus.supply_ok && armed && !pulse_on) begin
      next_filt_cnt = filt_cnt + W'(1);
      if (reached(filt_cnt, psr_pkg::SENSE_FILTER_CYC)) begin
        next_pulse_on = 1'b1;
        next_armed    = 1'b0;
        next_filt_cnt = '0;
      end
    end
    if (pulse_on) begin
      next_pulse_cnt = pulse_cnt + W'(1);
      if (reached(pulse_cnt, psr_pkg::INT_PULSE_CYC)) begin
        next_pulse_on  = 1'b0;
        next_pulse_cnt = '0;
      end
    end
    if (!RSTN_IN) begin
      next_filt_cnt  = '0;
      next_pulse_cnt = '0;
      next_pulse_on  = 1'b0;
      next_armed     = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    filt_cnt        <= next_filt_cnt;
    pulse_cnt       <= next_pulse_cnt;
    pulse_on        <= next_pulse_on;
    armed           <= next_armed;
    INTERRUPT_N_OUT <= ~next_pulse_on;
  end

  // watchdog state
  logic [W-1:0] wd_cnt;            // timeout counter
  logic [W-1:0] wds_cnt;           // status pulse counter
  logic         wds_on;            // status active
  logic         kick_prev;         // previous strobe level for edge detect
  logic [W-1:0] next_wd_cnt;
  logic [W-1:0] next_wds_cnt;
  logic         next_wds_on;
  logic         next_kick_prev;

  // strobe edges are looked for on the synchronised level only
  always_comb begin
    next_wd_cnt    = wd_cnt + W'(1);
    next_wds_cnt   = '0;
    next_wds_on    = wds_on;
    next_kick_prev = sync_bus.watchdog_kick_n;
    if (kick_prev && !sync_bus.watchdog_kick_n) begin
      next_wd_cnt = '0;
    end else if (reached(wd_cnt, WATCHDOG_CYC)) begin
      next_wd_cnt = '0;
      next_wds_on = 1'b1;
    end
    if (wds_on) begin
      next_wds_cnt = wds_cnt + W'(1);
      if (reached(wds_cnt, RESET_CYC)) begin
        next_wds_on  = 1'b0;
        next_wds_cnt = '0;
      end
    end
    if (!RESET_N_OUT || !RSTN_IN) begin
      next_wd_cnt  = '0;
      next_wds_cnt = '0;
      next_wds_on  = 1'b0;
    end
    if (!RSTN_IN) begin
      next_kick_prev = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    wd_cnt                 <= next_wd_cnt;
    wds_cnt                <= next_wds_cnt;
    wds_on                 <= next_wds_on;
    kick_prev              <= next_kick_prev;
    WATCHDOG_TIMEOUT_N_OUT <= ~next_wds_on;
  end
endmodule : psr_supervisor

// *** rtl/psr_sync.sv ***
/*
  two-flop synchronisers for the four asynchronous inputs.
  assumes a single clock; reset is synchronous, active low.
*/
`timescale 1ns/1ps
module psr_sync (
  input  wire logic      clock_in,
  input  wire logic      rstn_in,
  input  wire logic      supply_ok_in,
  input  wire logic      sense_low_in,
  input  wire logic      manual_reset_n_in,
  input  wire logic      watchdog_kick_n_in,
  psr_sync_if.producer   sync_bus
);
  logic [3:0] stage1;       // first flops, read only by stage2
  logic [3:0] stage2;       // second flops, safe to use
  logic [3:0] next_stage1;
  logic [3:0] next_stage2;

  // next values; reset leaves supply bad and pins idle high
  always_comb begin
    next_stage1 = {watchdog_kick_n_in, manual_reset_n_in, sense_low_in, supply_ok_in};
    next_stage2 = stage1;
    if (!rstn_in) begin
      next_stage1 = 4'hC;
      next_stage2 = 4'hC;
    end
  end

  always_ff @(posedge clock_in) begin
    stage1 <= next_stage1;
    stage2 <= next_stage2;
  end

  assign sync_bus.supply_ok       = stage2[0];
  assign sync_bus.sense_low       = stage2[1];
  assign sync_bus.manual_reset_n  = stage2[2];
  assign sync_bus.watchdog_kick_n = stage2[3];
endmodule : psr_sync

// *** rtl/psr_sync_if.sv ***
/*
  interface carrying synchronised input levels from the synchroniser to the core.
  assumes one clock domain.
*/
`timescale 1ns/1ps
interface psr_sync_if;
  logic supply_ok;        // supply above supply_trip_level
  logic sense_low;        // sense below sense_trip_level
  logic manual_reset_n;   // pushbutton level, active low
  logic watchdog_kick_n;  // strobe level
  modport producer (output supply_ok, output sense_low, output manual_reset_n, output watchdog_kick_n);
  modport consumer (input supply_ok, input sense_low, input manual_reset_n, input watchdog_kick_n);
endinterface : psr_sync_if

// *** tb/psr_cpu_model.sv ***
/* processor model: strobes the watchdog while out of reset and can
   wire the status output back to the pushbutton.
   assumes the supervisor's reset output and one clock. */
`timescale 1ns/1ps
module psr_cpu_model (
  input  wire logic       clock_in,
  input  wire logic       reset_n_in,  // processor runs only while high
  input  wire logic       kick_en_in,  // low models a hung program
  input  wire logic [7:0] kick_gap_in, // strobe period minus one
  input  wire logic       loop_en_in,  // status wired to pushbutton
  input  wire logic       status_n_in,
  input  wire logic       button_n_in,
  output logic            kick_n_out,
  output logic            manual_n_out
);
  logic [7:0] gap; // cycles since last strobe
  // strobe within timeout
  // two low cycles so the strobe survives the synchroniser
  always_ff @(posedge clock_in) begin
    if (!kick_en_in || !reset_n_in) begin
      gap        <= 8'h00;
      kick_n_out <= 1'b1;
    end else begin
      gap        <= (gap == kick_gap_in) ? 8'h00 : gap + 8'h01;
      kick_n_out <= gap < kick_gap_in - 8'h01;
    end
  end
  assign manual_n_out = button_n_in & (status_n_in | !loop_en_in);
endmodule : psr_cpu_model

// *** tb/psr_properties.sv ***
/* port checker for psr_supervisor.
   assumes one clock; the bind hands on the short counts. */
`timescale 1ns/1ps
module psr_properties #(
  parameter longint RESET_CYC    = 50,
  parameter longint WATCHDOG_CYC = 200
) (
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  input wire logic SUPPLY_OK_IN,
  input wire logic SENSE_LOW_IN,
  input wire logic MANUAL_RESET_N_IN,
  input wire logic WATCHDOG_KICK_N_IN,
  input wire logic RESET_N_OUT,
  input wire logic RESET_OUT,
  input wire logic INTERRUPT_N_OUT,
  input wire logic WATCHDOG_TIMEOUT_N_OUT
);
  // run lengths; start at zero so a long idle run before the first event never reads unknown
  int good_cnt = 0;
  int int_cnt  = 0;
  int sl_cnt   = 0;
  int wd_cnt   = 0;
  int wl_cnt   = 0;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RSTN_IN);
  // run lengths as counters, since repetitions stop at eight
  always_ff @(posedge CLOCK_IN) begin
    good_cnt <= (SUPPLY_OK_IN && MANUAL_RESET_N_IN) ? good_cnt + 1 : 0;
    int_cnt  <= INTERRUPT_N_OUT ? 0 : int_cnt + 1;
    sl_cnt   <= SENSE_LOW_IN ? sl_cnt + 1 : 0;
    wl_cnt   <= WATCHDOG_TIMEOUT_N_OUT ? 0 : wl_cnt + 1;
    // raw kick edge, so limits below leave room for the synchroniser
    wd_cnt   <= (!RESET_N_OUT || $fell(WATCHDOG_KICK_N_IN) || $fell(WATCHDOG_TIMEOUT_N_OUT)) ? 0 : wd_cnt + 1;
  end
  sequence s_supply_down; !SUPPLY_OK_IN [*8]; endsequence
  sequence s_reset_held; !RESET_N_OUT [*2]; endsequence
  a_reset_pair: assert property (RESET_OUT == !RESET_N_OUT)
    else $error("reset outputs not complementary");
  a_fail_resets: assert property (!SUPPLY_OK_IN |-> ##[0:5] !RESET_N_OUT)
    else $error("supply fail without reset");
  a_release_wait: assert property ($rose(RESET_N_OUT) |-> good_cnt >= RESET_CYC)
    else $error("reset released early");
  a_int_width: assert property ($rose(INTERRUPT_N_OUT) |-> int_cnt >= psr_pkg::INT_PULSE_CYC)
    else $error("interrupt pulse short");
  a_sense_filter: assert property ($fell(INTERRUPT_N_OUT) |-> sl_cnt >= psr_pkg::SENSE_FILTER_CYC)
    else $error("interrupt without filtered sense");
  a_sense_blocked: assert property (s_supply_down |=> !$fell(INTERRUPT_N_OUT))
    else $error("interrupt while supply low");
  a_wdog_quiet: assert property (s_reset_held |-> WATCHDOG_TIMEOUT_N_OUT)
    else $error("status active in reset");
  a_wdog_early: assert property ($fell(WATCHDOG_TIMEOUT_N_OUT) |-> wd_cnt >= WATCHDOG_CYC - 4)
    else $error("watchdog expired early");
  a_wdog_late: assert property (wd_cnt < WATCHDOG_CYC + 8)
    else $error("watchdog expiry missed");
  a_wdog_width: assert property ($rose(WATCHDOG_TIMEOUT_N_OUT) && RESET_N_OUT && $past(RESET_N_OUT)
    |-> wl_cnt >= RESET_CYC)
    else $error("status pulse short");
endmodule : psr_properties
bind psr_supervisor psr_properties #(.RESET_CYC(RESET_CYC), .WATCHDOG_CYC(WATCHDOG_CYC)) chk_u (
  .CLOCK_IN(CLOCK_IN), .RSTN_IN(RSTN_IN), .SUPPLY_OK_IN(SUPPLY_OK_IN), .SENSE_LOW_IN(SENSE_LOW_IN),
  .MANUAL_RESET_N_IN(MANUAL_RESET_N_IN), .WATCHDOG_KICK_N_IN(WATCHDOG_KICK_N_IN),
  .RESET_N_OUT(RESET_N_OUT), .RESET_OUT(RESET_OUT), .INTERRUPT_N_OUT(INTERRUPT_N_OUT),
  .WATCHDOG_TIMEOUT_N_OUT(WATCHDOG_TIMEOUT_N_OUT));

// *** tb/tb.sv ***
/* self-checking bench for psr_supervisor with a processor model.
   assumes shortened counts; one 40 MHz clock. */
`timescale 1ns/1ps
module tb;
  localparam int RST_N = 50;  // short reset stretch
  localparam int WD_N  = 200; // short watchdog
  logic       clk, rstn, sup, sense, btn, kick_en, loop_en;
  logic       kick_n, man_n, rst_n_o, rst_o, int_n, wds_n;
  logic [3:0] outs; // status, interrupt, reset, reset_n
  int         err_count, n_checks, c;
  assign outs = {wds_n, int_n, rst_o, rst_n_o};
  psr_supervisor #(.RESET_CYC(RST_N), .WATCHDOG_CYC(WD_N)) dut_u (
    .CLOCK_IN(clk), .RSTN_IN(rstn), .SUPPLY_OK_IN(sup), .SENSE_LOW_IN(sense),
    .MANUAL_RESET_N_IN(man_n), .WATCHDOG_KICK_N_IN(kick_n), .RESET_N_OUT(rst_n_o),
    .RESET_OUT(rst_o), .INTERRUPT_N_OUT(int_n), .WATCHDOG_TIMEOUT_N_OUT(wds_n));
  psr_cpu_model cpu_u (.clock_in(clk), .reset_n_in(rst_n_o), .kick_en_in(kick_en), .kick_gap_in(8'h64),
    .loop_en_in(loop_en), .status_n_in(wds_n), .button_n_in(btn), .kick_n_out(kick_n), .manual_n_out(man_n));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // bounded wait for an output level; c keeps the cycles spent
  task wait_out(input int idx, input logic v, input int n);
    for (c = 0; c < n && outs[idx] !== v; c++) @(posedge clk);
  endtask : wait_out
  task chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask : chk
  task t_supply;
    sup <= 1'b0;
    wait_out(0, 1'b0, 8);
    chk(c < 8 && rst_o === 1'b1, "supply fail");
    cyc(20);
    sup <= 1'b1;
    wait_out(0, 1'b1, RST_N + 20);
    chk(c >= RST_N && c < RST_N + 20, "supply stretch");
  endtask : t_supply
  task t_button;
    btn <= 1'b0;
    cyc(10);
    btn <= 1'b1;
    cyc(60);
    chk(rst_n_o === 1'b1, "glitch reset");
    btn <= 1'b0;
    cyc(100);
    chk(rst_n_o === 1'b0 && rst_o === 1'b1, "button ignored");
    btn <= 1'b1;
    wait_out(0, 1'b1, RST_N + 100);
    chk(c >= RST_N && c < RST_N + 100, "button stretch");
  endtask : t_button
  task t_sense;
    sense <= 1'b1;
    cyc(50);
    sense <= 1'b0;
    cyc(20);
    chk(int_n === 1'b1, "short excursion");
    sup <= 1'b0;
    cyc(10);
    sense <= 1'b1;
    cyc(300);
    chk(int_n === 1'b1, "supply low interrupt");
    sense <= 1'b0;
    sup <= 1'b1;
    wait_out(0, 1'b1, RST_N + 20);
    sense <= 1'b1;
    wait_out(2, 1'b0, 260);
    chk(c >= psr_pkg::SENSE_FILTER_CYC && c < 260, "filter delay");
    sense <= 1'b0;
    wait_out(2, 1'b1, 9000);
    chk(c >= psr_pkg::INT_PULSE_CYC, "interrupt width");
  endtask : t_sense
  task t_watchdog;
    chk(wds_n === 1'b1, "kicked watchdog expired");
    kick_en <= 1'b0;
    wait_out(3, 1'b0, WD_N + 20);
    chk(c < WD_N + 20, "no expiry");
    wait_out(3, 1'b1, RST_N + 20);
    chk(c >= RST_N, "status short");
    loop_en <= 1'b1;
    wait_out(0, 1'b0, WD_N + 100);
    loop_en <= 1'b0;
    cyc(5);
    chk(c < WD_N + 100 && wds_n === 1'b1, "status in reset");
    wait_out(0, 1'b1, RST_N + 60);
    wait_out(3, 1'b0, WD_N + 20);
    chk(c >= WD_N - 4 && c < WD_N + 10, "timeout start");
  endtask : t_watchdog
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    rstn = 1'b0;
    sup = 1'b1;
    sense = 1'b0;
    btn = 1'b1;
    kick_en = 1'b0;
    loop_en = 1'b0;
    cyc(4);
    rstn <= 1'b1;
    kick_en <= 1'b1;
    wait_out(0, 1'b1, RST_N + 20);
    t_supply();
    t_button();
    t_sense();
    t_watchdog();
    tally_and_finish();
  end
  // hang guard, about twice the expected run
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("mismatch %0t run hung", $time);
    tally_and_finish();
  end
endmodule : tb
